// ===== hw/meter_event_map.svh
// register map, field positions, reset values and timing counts of the event flag block
// Function
// R01: phase C reactive sign change sets first-status bit 12, sign in bit 6
// R02: second summed power sign change sets first-status bit 13, sign in bit 7
// R03: third summed power sign change sets first-status bit 18, sign in bit 8
// R04: falling edge of pulse output one sets first-status bit 14
// R05: falling edge of pulse output two sets first-status bit 15
// R06: falling edge of pulse output three sets first-status bit 16
// R07: pulse flags still set while the pin is disabled by bits 9-11
// R08: power type per pulse output from config fields [2:0], [5:3], [8:6]
// R09: end of each 8 kHz processing pass sets first-status bit 17
// R10: first-status bits 31 down to 19 always read zero
// R11: total no-load entry sets second-status bit 0, phase in bits [2:0]
// R12: fundamental no-load entry sets bit 1, phase in [5:3], zero without fundamental
// R13: apparent no-load entry sets second-status bit 2, phase in bits [8:6]
// R14: missing crossings set second-status bits 3-8: volts A,B,C then currents A,B,C
// R15: voltage A and B crossings set second-status bits 9 and 10
// R16: voltage C crossing sets bit 11, current A,B,C crossings bits 12-14
// R17: flags stay set until a one is written; zero writes keep them
`ifndef METER_EVENT_MAP_SVH
`define METER_EVENT_MAP_SVH

// register indices; byte address is four times the index
`define EVT_IDX_STATUS_FIRST  16'he502
`define EVT_IDX_STATUS_SECOND 16'he503
`define EVT_IDX_MASK_FIRST    16'he50a
`define EVT_IDX_MASK_SECOND   16'he50b
`define EVT_IDX_POWER_SIGN    16'he600
`define EVT_IDX_NOLOAD_PHASE  16'he601
`define EVT_IDX_PULSE_CONFIG  16'he610
`define EVT_IDX_ACCUM_MODE    16'he611

// first status fields
`define EVT_BIT_REV_REACT_C   12
`define EVT_BIT_REV_SUM_TWO   13
`define EVT_BIT_PULSE_BASE    14
`define EVT_BIT_PASS_DONE     17
`define EVT_BIT_REV_SUM_THREE 18
`define EVT_FIRST_IMPL_MASK   32'h0007_f000

// second status fields
`define EVT_BIT_NOLOAD_TOTAL  0
`define EVT_BIT_NOLOAD_FUND   1
`define EVT_BIT_NOLOAD_APP    2
`define EVT_BIT_TIMEOUT_BASE  3
`define EVT_BIT_CROSS_BASE    9
`define EVT_SECOND_IMPL_MASK  32'h0000_7fff

// sign register fields
`define EVT_BIT_SIGN_REACT_C   6
`define EVT_BIT_SIGN_SUM_TWO   7
`define EVT_BIT_SIGN_SUM_THREE 8

// pulse config: 3-bit selects from bit 0, disables from bit 9
`define EVT_SEL_WIDTH         3
`define EVT_BIT_DISABLE_BASE  9
`define EVT_PULSE_CFG_MASK    32'h0000_0fff
`define EVT_PULSE_CFG_RESET   32'h0000_0000

// accumulation mode: reactive reversal source select
`define EVT_BIT_REACT_SEL     7
`define EVT_ACCUM_MASK        32'h0000_00ff
`define EVT_ACCUM_RESET       32'h0000_0000

`define EVT_STATUS_RESET      32'h0000_0000
`define EVT_MASK_RESET        32'h0000_0000

// timing
`define EVT_CLK_PERIOD_NS     10
`define EVT_PULSE_LOW_US      80000

`endif

// ===== hw/meter_event_pkg.sv
// types shared by the event flag block
package meter_event_pkg;

  typedef enum logic [1:0] {
    PULSE_IDLE = 2'b01,
    PULSE_LOW  = 2'b10
  } pulse_state_t;

  typedef logic [31:0] reg_word_t;

endpackage

// ===== hw/meter_event_status_flags.sv
// event status flags of a three-phase metering core with a wishbone register port
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "meter_event_map.svh"

module meter_event_status_flags #(
  parameter bit          HAS_REACTIVE = 1'b1,
  parameter bit          HAS_FUND     = 1'b1,
  parameter int unsigned PULSE_CYCLES =
    (`EVT_PULSE_LOW_US * 1000) / `EVT_CLK_PERIOD_NS,
  parameter int unsigned CNT_W        = 24,
  parameter int unsigned ADR_W        = 18
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  input  wire logic             we_i,
  input  wire logic [ADR_W-1:0] adr_i,
  input  wire logic [3:0]       sel_i,
  input  wire logic [31:0]      dat_i,
  output logic      [31:0]      dat_o,
  output logic                  ack_o,
  input  wire logic             reactiveSignTotalC,
  input  wire logic             reactiveSignFundC,
  input  wire logic             sumTwoSign,
  input  wire logic             sumThreeSign,
  input  wire logic [7:0]       powerPulseReq,
  input  wire logic             dspPassDone,
  input  wire logic [2:0]       noloadTotal,
  input  wire logic [2:0]       noloadFund,
  input  wire logic [2:0]       noloadApparent,
  input  wire logic [5:0]       crossTimeout,
  input  wire logic [5:0]       crossDetect,
  output logic                  freqOutOnePulse,
  output logic                  freqOutTwoPulse,
  output logic                  freqOutThreePulse,
  output logic                  irq
);

  // refuse sizes that the index decode or the pulse counter cannot serve
  if (ADR_W < 18) begin : g_bad_adr
    $error("ADR_W must hold a 16-bit register index above the byte lanes");
  end
  if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt
    $error("CNT_W must lie between 1 and 32");
  end
  if (PULSE_CYCLES < 1 || 64'(PULSE_CYCLES) >= (64'd1 << CNT_W)) begin : g_bad_pulse
    $error("PULSE_CYCLES must be at least one and fit in CNT_W bits");
  end

  // ---------------- bus slave ----------------
  logic [15:0]                   regIdx;
  logic                          busReq;
  logic                          wrCommit;
  logic [31:0]                   laneMask;
  logic [31:0]                   wrBits;
  meter_event_pkg::reg_word_t    rdData;

  logic [31:0] statusFirst_q;
  logic [31:0] statusFirst_d;
  logic [31:0] statusSecond_q;
  logic [31:0] statusSecond_d;
  logic [31:0] maskFirst_q;
  logic [31:0] maskSecond_q;
  logic [31:0] pulseCfg_q;
  logic [31:0] accumCfg_q;
  logic [31:0] signReg;
  logic [31:0] noloadReg;

  assign regIdx   = adr_i[17:2];
  assign busReq   = cyc_i & stb_i;
  // the write lands on the edge where the master sees ack
  assign wrCommit = busReq & we_i & ack_o;
  // byte lanes limit every write, clears included
  assign laneMask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign wrBits   = dat_i & laneMask;

  // one wait state: ack follows the taken edge and never stretches
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= busReq & ~ack_o;
    end
  end

  always_comb begin
    rdData = 32'h0000_0000;
    case (regIdx)
      `EVT_IDX_STATUS_FIRST: begin
        rdData = statusFirst_q;
      end
      `EVT_IDX_STATUS_SECOND: begin
        rdData = statusSecond_q;
      end
      `EVT_IDX_MASK_FIRST: begin
        rdData = maskFirst_q;
      end
      `EVT_IDX_MASK_SECOND: begin
        rdData = maskSecond_q;
      end
      `EVT_IDX_POWER_SIGN: begin
        rdData = signReg;
      end
      `EVT_IDX_NOLOAD_PHASE: begin
        rdData = noloadReg;
      end
      `EVT_IDX_PULSE_CONFIG: begin
        rdData = pulseCfg_q;
      end
      `EVT_IDX_ACCUM_MODE: begin
        rdData = accumCfg_q;
      end
      default: begin
        rdData = 32'h0000_0000;
      end
    endcase
  end

  // read data caught at the taken edge, held until the next access
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dat_o <= 32'h0000_0000;
    end else if (busReq & ~ack_o) begin
      dat_o <= rdData;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      maskFirst_q  <= `EVT_MASK_RESET;
      maskSecond_q <= `EVT_MASK_RESET;
      pulseCfg_q   <= `EVT_PULSE_CFG_RESET;
      accumCfg_q   <= `EVT_ACCUM_RESET;
    end else if (wrCommit) begin
      case (regIdx)
        `EVT_IDX_MASK_FIRST: begin
          maskFirst_q <= ((maskFirst_q & ~laneMask) | wrBits) & `EVT_FIRST_IMPL_MASK;
        end
        `EVT_IDX_MASK_SECOND: begin
          maskSecond_q <= ((maskSecond_q & ~laneMask) | wrBits) & `EVT_SECOND_IMPL_MASK;
        end
        `EVT_IDX_PULSE_CONFIG: begin
          pulseCfg_q <= ((pulseCfg_q & ~laneMask) | wrBits) & `EVT_PULSE_CFG_MASK;
        end
        `EVT_IDX_ACCUM_MODE: begin
          accumCfg_q <= ((accumCfg_q & ~laneMask) | wrBits) & `EVT_ACCUM_MASK;
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------- sign tracking ----------------
  logic reactCSrc;
  logic signReactC_q;
  logic signSumTwo_q;
  logic signSumThree_q;
  logic revReactC;
  logic revSumTwo;
  logic revSumThree;

  // R01 reactive source select
  assign reactCSrc   = accumCfg_q[`EVT_BIT_REACT_SEL] ? reactiveSignFundC : reactiveSignTotalC;
  // R01 flag only on reactive parts
  assign revReactC   = HAS_REACTIVE & (reactCSrc != signReactC_q);
  // R02 sum two reversal
  assign revSumTwo   = sumTwoSign != signSumTwo_q;
  // R03 sum three reversal
  assign revSumThree = sumThreeSign != signSumThree_q;

  // signs start positive; a negative power after reset counts as a reversal
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      signReactC_q   <= 1'b0;
      signSumTwo_q   <= 1'b0;
      signSumThree_q <= 1'b0;
    end else begin
      signReactC_q   <= HAS_REACTIVE & reactCSrc;
      signSumTwo_q   <= sumTwoSign;
      signSumThree_q <= sumThreeSign;
    end
  end

  // read-only view of the last sampled signs
  always_comb begin
    signReg = 32'h0000_0000;
    // R01 recorded reactive sign
    signReg[`EVT_BIT_SIGN_REACT_C]   = signReactC_q;
    // R02 recorded sum two sign
    signReg[`EVT_BIT_SIGN_SUM_TWO]   = signSumTwo_q;
    // R03 recorded sum three sign
    signReg[`EVT_BIT_SIGN_SUM_THREE] = signSumThree_q;
  end

  // ---------------- pulse outputs ----------------
  logic [2:0] pulseFall;
  logic [2:0] pulsePin_q;

  for (genvar k = 0; k < 3; k++) begin : g_pulse
    meter_event_pkg::pulse_state_t state_q;
    meter_event_pkg::pulse_state_t state_d;
    logic [CNT_W-1:0]              cnt_q;
    logic [2:0]                    powerSel;
    logic                          req;
    logic                          pinOff;

    // R08 power type select field
    assign powerSel = pulseCfg_q[`EVT_SEL_WIDTH*k +: `EVT_SEL_WIDTH];
    assign req      = powerPulseReq[powerSel];
    assign pinOff   = pulseCfg_q[`EVT_BIT_DISABLE_BASE + k];

    always_comb begin
      state_d = state_q;
      case (state_q)
        meter_event_pkg::PULSE_IDLE: begin
          if (req) begin
            state_d = meter_event_pkg::PULSE_LOW;
          end
        end
        meter_event_pkg::PULSE_LOW: begin
          if (cnt_q == CNT_W'(PULSE_CYCLES - 1)) begin
            state_d = meter_event_pkg::PULSE_IDLE;
          end
        end
        default: begin
          state_d = meter_event_pkg::PULSE_IDLE;
        end
      endcase
    end

    // requests during a pulse are dropped; the pulse width sets the top rate
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        state_q <= meter_event_pkg::PULSE_IDLE;
        cnt_q   <= '0;
      end else begin
        state_q <= state_d;
        cnt_q   <= (state_d == meter_event_pkg::PULSE_LOW &&
                    state_q == meter_event_pkg::PULSE_LOW) ? cnt_q + 1'b1 : '0;
      end
    end

    // R07 internal pulse runs regardless of disable
    assign pulseFall[k] = (state_q == meter_event_pkg::PULSE_IDLE) &&
                          (state_d == meter_event_pkg::PULSE_LOW);

    // pin idles high; a blocked pin stays high through the whole pulse
    // R07 disable only blocks the pin
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        pulsePin_q[k] <= 1'b1;
      end else begin
        pulsePin_q[k] <= pinOff | (state_d == meter_event_pkg::PULSE_IDLE);
      end
    end
  end

  assign freqOutOnePulse   = pulsePin_q[0];
  assign freqOutTwoPulse   = pulsePin_q[1];
  assign freqOutThreePulse = pulsePin_q[2];

  // ---------------- no-load tracking ----------------
  logic [2:0] nlTotal_q;
  logic [2:0] nlFund_q;
  logic [2:0] nlApp_q;
  logic [2:0] nlFundIn;

  // R12 no fundamental path, no flag
  assign nlFundIn = HAS_FUND ? noloadFund : 3'h0;

  // last levels mark entry; leaving no-load sets nothing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nlTotal_q <= 3'h0;
      nlFund_q  <= 3'h0;
      nlApp_q   <= 3'h0;
    end else begin
      nlTotal_q <= noloadTotal;
      nlFund_q  <= nlFundIn;
      nlApp_q   <= noloadApparent;
    end
  end

  always_comb begin
    noloadReg = 32'h0000_0000;
    // R11 total no-load phases
    noloadReg[2:0] = nlTotal_q;
    // R12 fundamental no-load phases
    noloadReg[5:3] = nlFund_q;
    // R13 apparent no-load phases
    noloadReg[8:6] = nlApp_q;
  end

  // ---------------- status registers ----------------
  logic [31:0] setFirst;
  logic [31:0] setSecond;
  logic [31:0] clrFirst;
  logic [31:0] clrSecond;

  always_comb begin
    setFirst = 32'h0000_0000;
    // R01 reactive reversal flag
    setFirst[`EVT_BIT_REV_REACT_C]   = revReactC;
    // R02 sum two reversal flag
    setFirst[`EVT_BIT_REV_SUM_TWO]   = revSumTwo;
    // R04 pulse one falling edge
    setFirst[`EVT_BIT_PULSE_BASE]    = pulseFall[0];
    // R05 pulse two falling edge
    setFirst[`EVT_BIT_PULSE_BASE+1]  = pulseFall[1];
    // R06 pulse three falling edge
    setFirst[`EVT_BIT_PULSE_BASE+2]  = pulseFall[2];
    // R09 processing pass done
    setFirst[`EVT_BIT_PASS_DONE]     = dspPassDone;
    // R03 sum three reversal flag
    setFirst[`EVT_BIT_REV_SUM_THREE] = revSumThree;
  end

  // timeouts and crossings arrive as one-cycle strobes
  always_comb begin
    setSecond = 32'h0000_0000;
    // R11 entry into total no-load
    setSecond[`EVT_BIT_NOLOAD_TOTAL] = |(noloadTotal & ~nlTotal_q);
    // R12 entry into fundamental no-load
    setSecond[`EVT_BIT_NOLOAD_FUND]  = |(nlFundIn & ~nlFund_q);
    // R13 entry into apparent no-load
    setSecond[`EVT_BIT_NOLOAD_APP]   = |(noloadApparent & ~nlApp_q);
    // R14 missing crossings, volts then currents
    setSecond[`EVT_BIT_TIMEOUT_BASE +: 6] = crossTimeout;
    // R15 R16 detected crossings, volts then currents
    setSecond[`EVT_BIT_CROSS_BASE +: 6]   = crossDetect;
  end

  // R17 write one to clear
  assign clrFirst  = (wrCommit && regIdx == `EVT_IDX_STATUS_FIRST) ? wrBits : 32'h0000_0000;
  assign clrSecond = (wrCommit && regIdx == `EVT_IDX_STATUS_SECOND) ? wrBits : 32'h0000_0000;

  // R17 set beats a same-cycle clear
  // R10 reserved bits masked to zero
  assign statusFirst_d  = ((statusFirst_q & ~clrFirst) | setFirst) & `EVT_FIRST_IMPL_MASK;
  assign statusSecond_d = ((statusSecond_q & ~clrSecond) | setSecond) & `EVT_SECOND_IMPL_MASK;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      statusFirst_q <= `EVT_STATUS_RESET;
    end else begin
      statusFirst_q <= statusFirst_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      statusSecond_q <= `EVT_STATUS_RESET;
    end else begin
      statusSecond_q <= statusSecond_d;
    end
  end

  // ---------------- interrupt ----------------
  // registered level: lags the flag by a cycle but never glitches
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(statusFirst_q & maskFirst_q) | |(statusSecond_q & maskSecond_q);
    end
  end

endmodule
`default_nettype wire

// ===== bench/meter_event_status_flags_asserts.sv
// bus and pulse pin assertions for the event flag block
`timescale 1ns/1ps
`default_nettype none
module meter_event_status_flags_asserts #(
  parameter int unsigned PULSE_CYCLES = 4
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire logic [31:0] dat_o,
  input wire logic [7:0]  powerPulseReq,
  input wire logic        freqOutOnePulse,
  input wire logic        freqOutTwoPulse,
  input wire logic        freqOutThreePulse
);
  // counts how long each watched pin has been low
  int unsigned lowOne_q;
  int unsigned lowThree_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lowOne_q <= 0;
      lowThree_q <= 0;
    end else begin
      lowOne_q <= freqOutOnePulse ? 0 : lowOne_q + 1;
      lowThree_q <= freqOutThreePulse ? 0 : lowThree_q + 1;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_ack_one_cycle: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered next cycle");
  a_ack_cause: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("ack without request");
  a_read_hold: assert property (!(cyc_i && stb_i && !ack_o) |=> $stable(dat_o))
    else $error("read data moved without access");
  a_one_fall_cause: assert property ($fell(freqOutOnePulse) |-> $past(|powerPulseReq))
    else $error("pin one fell without request");
  a_other_fall_cause: assert property (
    $fell(freqOutTwoPulse) || $fell(freqOutThreePulse) |-> $past(|powerPulseReq))
    else $error("pin two or three fell without request");
  a_one_low_len: assert property ($rose(freqOutOnePulse) |-> lowOne_q == PULSE_CYCLES)
    else $error("pin one low time wrong");
  a_one_low_max: assert property (lowOne_q <= PULSE_CYCLES)
    else $error("pin one low too long");
  a_three_low_len: assert property ($rose(freqOutThreePulse) |-> lowThree_q == PULSE_CYCLES)
    else $error("pin three low time wrong");
endmodule
bind meter_event_status_flags meter_event_status_flags_asserts #(
  .PULSE_CYCLES(PULSE_CYCLES)
) u_meter_event_status_flags_asserts (
  .clk(clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .dat_o(dat_o),
  .powerPulseReq(powerPulseReq), .freqOutOnePulse(freqOutOnePulse),
  .freqOutTwoPulse(freqOutTwoPulse), .freqOutThreePulse(freqOutThreePulse)
);
`default_nettype wire

// ===== bench/test_meter_event_status_flags.sv
// self-checking bench for the event flag block
`timescale 1ns/1ps
`default_nettype none
`include "meter_event_map.svh"
module test_meter_event_status_flags;
  // short pin pulse keeps the run brief
  localparam int unsigned PC = 4;
  localparam logic [15:0] SF = `EVT_IDX_STATUS_FIRST, SS = `EVT_IDX_STATUS_SECOND,
    MF = `EVT_IDX_MASK_FIRST, MS = `EVT_IDX_MASK_SECOND, SG = `EVT_IDX_POWER_SIGN,
    NP = `EVT_IDX_NOLOAD_PHASE, CF = `EVT_IDX_PULSE_CONFIG, AM = `EVT_IDX_ACCUM_MODE;
  logic        clk = '0, rst = 1'h1, cyc = '0, stb = '0, we = '0;
  logic        sgnTot = '0, sgnFund = '0, sumTwo = '0, sumThree = '0, done = '0;
  logic [17:0] adr = '0;
  logic [3:0]  sel = 4'hf;
  logic [31:0] wdat = '0, dato;
  logic [7:0]  req = '0;
  logic [2:0]  nlTot = '0, nlFund = '0, nlApp = '0;
  logic [5:0]  crossTo = '0, crossDet = '0;
  logic        ack, p1, p2, p3, irq;
  int          nErrors = 0, nChecks = 0, cycles = 0;

  meter_event_status_flags #(.PULSE_CYCLES(PC)) u_meter_event_status_flags (
    .clk(clk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(dato), .ack_o(ack),
    .reactiveSignTotalC(sgnTot), .reactiveSignFundC(sgnFund), .sumTwoSign(sumTwo),
    .sumThreeSign(sumThree), .powerPulseReq(req), .dspPassDone(done),
    .noloadTotal(nlTot), .noloadFund(nlFund), .noloadApparent(nlApp),
    .crossTimeout(crossTo), .crossDetect(crossDet), .freqOutOnePulse(p1),
    .freqOutTwoPulse(p2), .freqOutThreePulse(p3), .irq(irq)
  );

  always #5 clk = ~clk;

  task automatic conclude();
    $display("checks %0d errors %0d", nChecks, nErrors);
    if (nErrors == 0 && nChecks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // a hang counts as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      nErrors++;
      conclude();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    nChecks++;
    if (seen !== want) begin
      nErrors++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  // entered just after a rising edge; leaves one idle cycle behind
  task automatic wb(input logic w, input logic [15:0] idx, input logic [31:0] d,
                    output logic [31:0] q);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= {idx, 2'h0};
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'h1) @(posedge clk);
    q = dato;
    cyc <= '0;
    stb <= '0;
    we <= '0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] q;
    wb(1'h1, idx, d, q);
  endtask

  task automatic rdc(input logic [15:0] idx, input logic [31:0] want);
    logic [31:0] q;
    wb('0, idx, '0, q);
    check(q, want);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic t_reset();
    rdc(SF, '0);
    rdc(SS, '0);
    check(32'({p3, p2, p1}), 32'h7);
  endtask

  task automatic t_sign();
    sgnTot <= 1'h1;
    sgnFund <= 1'h1;
    sumTwo <= 1'h1;
    sumThree <= 1'h1;
    tick(2);
    rdc(SF, 32'h0004_3000);
    rdc(SG, 32'h0000_01c0);
    wr(SF, '0);
    rdc(SF, 32'h0004_3000);
    wr(SF, 32'h0000_1000);
    rdc(SF, 32'h0004_2000);
    wr(AM, 32'h0000_0080);
    wr(SF, 32'hffff_ffff);
    // total source no longer watched
    sgnTot <= '0;
    tick(2);
    rdc(SF, '0);
    sgnFund <= '0;
    tick(2);
    rdc(SF, 32'h0000_1000);
    rdc(SG, 32'h0000_0180);
    wr(SF, 32'hffff_ffff);
  endtask

  task automatic t_pulse();
    // sel 2, 5, 7; pin two blocked
    wr(CF, 32'h0000_05ea);
    rdc(CF, 32'h0000_05ea);
    req <= 8'ha5;
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    check(32'({p3, p2, p1}), 32'h2);
    @(posedge clk);
    req <= 8'h04;
    @(posedge clk);
    req <= '0;
    repeat (PC - 2) @(negedge clk);
    check(32'(p1), 32'h0);
    @(negedge clk);
    check(32'(p1), 32'h1);
    @(posedge clk);
    rdc(SF, 32'h0001_c000);
    wr(MF, 32'h0000_4000);
    @(negedge clk);
    check(32'(irq), 32'h1);
    @(posedge clk);
    wr(SF, 32'h0000_4000);
    @(negedge clk);
    check(32'(irq), 32'h0);
    @(posedge clk);
    rdc(SF, 32'h0001_8000);
    done <= 1'h1;
    @(posedge clk);
    done <= '0;
    wr(SF, 32'h0001_8000);
    rdc(SF, 32'h0002_0000);
  endtask

  task automatic t_second();
    nlTot <= 3'h2;
    nlFund <= 3'h4;
    nlApp <= 3'h1;
    crossTo <= 6'h21;
    crossDet <= 6'h3f;
    @(posedge clk);
    crossTo <= '0;
    crossDet <= '0;
    tick(2);
    rdc(SS, 32'h0000_7f0f);
    rdc(NP, 32'h0000_0062);
    wr(NP, '0);
    rdc(NP, 32'h0000_0062);
    sel <= 4'h1;
    wr(SS, 32'hffff_ffff);
    sel <= 4'hf;
    rdc(SS, 32'h0000_7f00);
    wr(MS, 32'h0000_0100);
    @(negedge clk);
    check(32'(irq), 32'h1);
    @(posedge clk);
    wr(SS, 32'hffff_ffff);
    @(negedge clk);
    check(32'(irq), 32'h0);
    @(posedge clk);
    wr(16'h0100, 32'hffff_ffff);
    rdc(16'h0100, '0);
  endtask

  // mid-run reset while sum signs stay negative and no-load levels stay present
  task automatic t_rerun();
    rst <= 1'h1;
    tick(2);
    check(32'({irq, p3, p2, p1}), 32'h7);
    rst <= '0;
    @(posedge clk);
    rdc(MS, '0);
    rdc(SF, 32'h0004_2000);
    rdc(SS, 32'h0000_0007);
    check(32'({irq, p3, p2, p1}), 32'h7);
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst <= '0;
    @(posedge clk);
    t_reset();
    t_sign();
    t_pulse();
    t_second();
    t_rerun();
    conclude();
  end
endmodule
`default_nettype wire
